// ### verilog/ipsl_top.sv
// priority threshold, in-service, request, status, halt and shared
// request logic of the interrupt controller; registers over AHB-Lite
// assumes channel control registers supply mask and priority, and the
// core supplies vector fetch, end-of-interrupt and return strobes
`timescale 1ns/10ps
module ipsl_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [ipsl_pkg::NUM_EXT-1:0] external_interrupt_pins,
    input wire logic [ipsl_pkg::NUM_GPIO-1:0] general_io_pin,
    input wire logic [2:0] timer_event,
    input wire logic [3:0] dma_event,
    input wire logic [3:0] internal_request,
    input wire logic pwd_rise_event,
    input wire logic pwd_fall_event,
    input wire logic [ipsl_pkg::NUM_CH-1:0] channel_mask,
    input wire logic [3*ipsl_pkg::NUM_CH-1:0] channel_priority_field,
    input wire logic vector_fetch,
    input wire logic [3:0] vector_channel,
    input wire logic [1:0] vector_device,
    input wire logic eoi_specific,
    input wire logic [3:0] eoi_channel,
    input wire logic eoi_nonspecific,
    input wire logic nmi_event,
    input wire logic interrupt_return,
    output logic [ipsl_pkg::NUM_CH-1:0] channel_request_bits,
    output logic [ipsl_pkg::NUM_CH-1:0] in_service_bits,
    output logic [ipsl_pkg::NUM_CH-1:0] request_allowed,
    output logic dma_halt_flag,
    output logic shared_channel_request
);
    import ipsl_pkg::*;

    logic [THR_W-1:0] threshold_reg;
    logic [TIM_W-1:0] timer_status_reg;
    logic [DMA_W-1:0] dma_status_reg;
    logic [15:0] shared_status_reg;
    logic [15:0] shared_mask_reg;
    logic [8:0] ext_pol_reg;
    logic [7:0] gpio_pol_reg;
    logic [NUM_CH-1:0] trigger_mode_reg;
    logic [CFG_W-1:0] source_cfg_reg;
    logic [NUM_CH-1:0] latch_reg;
    logic [NUM_CH-1:0] prev_active_reg;
    logic [NUM_EXT-1:0] ext_sync;
    logic [NUM_GPIO-1:0] gpio_sync;
    logic [NUM_EXT-1:0] ext_active;
    logic [NUM_GPIO-1:0] gpio_active;
    logic [NUM_CH-1:0] pin_active;
    logic [NUM_CH-1:0] is_pin;
    logic [NUM_CH-1:0] edge_seen;
    logic [NUM_CH-1:0] internal_set;
    logic [NUM_CH-1:0] service_set;
    logic [NUM_CH-1:0] service_clear;
    logic [NUM_CH-1:0] nonspec_sel;
    logic [9:0] dp_index_reg;
    logic dp_write_reg;
    logic dp_valid_reg;
    logic addr_ok;
    logic take_req;
    logic wr_en;
    logic [15:0] wd;
    logic [15:0] read_mux;
    logic [TIM_W-1:0] tim_fetch_clr;
    logic [DMA_W-1:0] dma_fetch_clr;

    ipsl_sync #(.WIDTH(NUM_EXT)) u_ext_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in(external_interrupt_pins),
        .sync_out(ext_sync)
    );

    ipsl_sync #(.WIDTH(NUM_GPIO)) u_gpio_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in(general_io_pin),
        .sync_out(gpio_sync)
    );

    assign ext_active = ext_sync ~^ ext_pol_reg;
    assign gpio_active = gpio_sync ~^ gpio_pol_reg;

    // ---------------- bus slave ----------------
    // zero wait state: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign take_req = hsel && hready && htrans[1];
    assign addr_ok = (haddr[31:12] == 20'h0_0000) && (haddr[1:0] == 2'b00)
        && (hsize == HSIZE_WORD);
    assign wr_en = dp_valid_reg && dp_write_reg;
    assign wd = hwdata[15:0];

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_index_reg <= '0;
        end
        else
        begin
            dp_valid_reg <= take_req && addr_ok;
            dp_write_reg <= hwrite;
            dp_index_reg <= haddr[11:2];
        end
    end

    always_comb
    begin
        read_mux = 16'h0000;
        case (haddr[11:2])
            IDX_PRIORITY_THRESHOLD: read_mux = {13'h0000, threshold_reg};
            IDX_IN_SERVICE: read_mux = {1'b0, in_service_bits};
            IDX_CHANNEL_REQUEST: read_mux = {1'b0, channel_request_bits};
            IDX_TIMER_DMA_STATUS:
                read_mux = {9'h000, dma_status_reg, timer_status_reg};
            IDX_DMA_HALT: read_mux = {dma_halt_flag, 15'h0000};
            IDX_SHARED_STATUS: read_mux = shared_status_reg;
            IDX_SHARED_MASK: read_mux = shared_mask_reg;
            IDX_EXT_POLARITY: read_mux = {7'h7f, ext_pol_reg};
            IDX_GPIO_POLARITY: read_mux = {gpio_pol_reg, 8'hff};
            IDX_TRIGGER_MODE: read_mux = {1'b0, trigger_mode_reg};
            IDX_SOURCE_CONFIG: read_mux = {13'h0000, source_cfg_reg};
            default: read_mux = 16'h0000;
        endcase
    end

    // read data is captured at the address phase so it stands as a flop
    always_ff @(posedge mclk)
    begin
        if (rst)
            hrdata <= UNMAPPED_READ;
        else if (take_req && !hwrite)
            hrdata <= addr_ok ? {16'h0000, read_mux} : UNMAPPED_READ;
    end

    // ---------------- software-owned configuration ----------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            threshold_reg <= THRESHOLD_RESET;
            shared_mask_reg <= SHARED_MASK_RESET;
            ext_pol_reg <= EXT_POL_RESET;
            gpio_pol_reg <= GPIO_POL_RESET;
            trigger_mode_reg <= '0;
            source_cfg_reg <= '0;
        end
        else if (wr_en)
        begin
            case (dp_index_reg)
                IDX_PRIORITY_THRESHOLD: threshold_reg <= wd[THR_W-1:0];
                // reserved bit 0 stays one whatever is written
                IDX_SHARED_MASK: shared_mask_reg <= {wd[15:1], 1'b1};
                IDX_EXT_POLARITY: ext_pol_reg <= wd[8:0];
                IDX_GPIO_POLARITY: gpio_pol_reg <= wd[15:8];
                IDX_TRIGGER_MODE: trigger_mode_reg <= wd[NUM_CH-1:0];
                IDX_SOURCE_CONFIG: source_cfg_reg <= wd[CFG_W-1:0];
                default: ;
            endcase
        end
    end

    // ---------------- timer and DMA status ----------------
    always_comb
    begin
        tim_fetch_clr = '0;
        dma_fetch_clr = '0;
        if (vector_fetch && vector_channel == 4'(CH_TIMER))
            tim_fetch_clr[vector_device] = 1'b1;
        if (vector_fetch && vector_channel == 4'(CH_DMA_LO)
            && source_cfg_reg[CFG_CH9_DMA])
            dma_fetch_clr[{1'b0, vector_device[0]}] = 1'b1;
        if (vector_fetch && vector_channel == 4'(CH_DMA_HI)
            && source_cfg_reg[CFG_CH10_DMA])
            dma_fetch_clr[{1'b1, vector_device[0]}] = 1'b1;
    end

    // a new device event wins over a software or fetch clear
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            timer_status_reg <= '0;
            dma_status_reg <= '0;
        end
        else
        begin
            if (wr_en && dp_index_reg == IDX_TIMER_DMA_STATUS)
            begin
                timer_status_reg <= (timer_status_reg
                    & wd[TIM_LSB +: TIM_W] & ~tim_fetch_clr)
                    | timer_event;
                dma_status_reg <= (dma_status_reg
                    & wd[DMA_LSB +: DMA_W] & ~dma_fetch_clr)
                    | dma_event;
            end
            else
            begin
                timer_status_reg <= (timer_status_reg & ~tim_fetch_clr)
                    | timer_event;
                dma_status_reg <= (dma_status_reg & ~dma_fetch_clr)
                    | dma_event;
            end
        end
    end

    // ---------------- DMA halt ----------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            dma_halt_flag <= 1'b0;
        else if (nmi_event)
            dma_halt_flag <= 1'b1;
        else if (interrupt_return)
            dma_halt_flag <= 1'b0;
        else if (wr_en && dp_index_reg == IDX_DMA_HALT)
            dma_halt_flag <= wd[HALT_BIT];
    end

    // ---------------- shared channel 14 ----------------
    // sources are level only: the pin must be held until served
    always_ff @(posedge mclk)
    begin
        if (rst)
            shared_status_reg <= '0;
        else
            shared_status_reg <= {gpio_active, ext_active[SH_EXT_W:1], 1'b0}
                & ~shared_mask_reg;
    end

    assign shared_channel_request = |shared_status_reg;

    // ---------------- channel sources ----------------
    always_comb
    begin
        pin_active = '0;
        is_pin = '0;
        internal_set = '0;
        pin_active[1] = ext_active[0];
        pin_active[2] = ext_active[1];
        pin_active[3] = ext_active[2];
        pin_active[8] = ext_active[3];
        pin_active[CH_DMA_LO] = ext_active[4];
        pin_active[CH_DMA_HI] = ext_active[5];
        pin_active[11] = ext_active[6];
        pin_active[CH_PWD_A] = ext_active[7];
        pin_active[CH_PWD_B] = ext_active[8];
        is_pin = 15'h3f0e;
        is_pin[CH_DMA_LO] = !source_cfg_reg[CFG_CH9_DMA];
        is_pin[CH_DMA_HI] = !source_cfg_reg[CFG_CH10_DMA];
        if (source_cfg_reg[CFG_PWD])
        begin
            is_pin[CH_PWD_A] = 1'b0;
            is_pin[CH_PWD_B] = 1'b0;
            internal_set[CH_PWD_A] = pwd_fall_event;
            internal_set[CH_PWD_B] = pwd_rise_event;
        end
        internal_set[7:4] = internal_request;
    end

    assign edge_seen = pin_active & ~prev_active_reg;

    always_ff @(posedge mclk)
    begin
        if (rst)
            prev_active_reg <= '0;
        else
            prev_active_reg <= pin_active;
    end

    // edge and internal requests are remembered until service starts;
    // an arrival in the service cycle is kept
    always_ff @(posedge mclk)
    begin
        if (rst)
            latch_reg <= '0;
        else
            latch_reg <= (latch_reg & ~service_set)
                | (edge_seen & is_pin & trigger_mode_reg)
                | internal_set;
    end

    always_comb
    begin
        channel_request_bits = '0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (is_pin[c] && !trigger_mode_reg[c])
                channel_request_bits[c] = pin_active[c];
            else
                channel_request_bits[c] = latch_reg[c];
        end
        channel_request_bits[CH_TIMER] = |timer_status_reg;
        if (!is_pin[CH_DMA_LO])
            channel_request_bits[CH_DMA_LO] = |dma_status_reg[1:0];
        if (!is_pin[CH_DMA_HI])
            channel_request_bits[CH_DMA_HI] = |dma_status_reg[3:2];
        channel_request_bits[CH_SHARED] = shared_channel_request;
    end

    // larger code means lower priority; code above threshold is blocked
    always_comb
    begin
        request_allowed = '0;
        for (int c = 0; c < NUM_CH; c++)
            request_allowed[c] = channel_request_bits[c] && !channel_mask[c]
                && (channel_priority_field[3*c +: 3] <= threshold_reg);
    end

    // ---------------- in-service ----------------
    // a non-specific end clears the best-priority active routine,
    // ties going to the lower channel number
    always_comb
    begin
        logic [2:0] best;
        logic found;
        best = 3'h7;
        found = 1'b0;
        nonspec_sel = '0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (in_service_bits[c] && (!found
                || channel_priority_field[3*c +: 3] < best))
            begin
                best = channel_priority_field[3*c +: 3];
                found = 1'b1;
                nonspec_sel = '0;
                nonspec_sel[c] = 1'b1;
            end
        end
    end

    always_comb
    begin
        service_set = '0;
        service_clear = '0;
        if (vector_fetch && vector_channel < 4'(NUM_CH))
            service_set[vector_channel] = 1'b1;
        if (eoi_specific && eoi_channel < 4'(NUM_CH))
            service_clear[eoi_channel] = 1'b1;
        if (eoi_nonspecific)
            service_clear = service_clear | nonspec_sel;
    end

    // a fetch in the same cycle as an end wins so service is not lost
    always_ff @(posedge mclk)
    begin
        if (rst)
            in_service_bits <= '0;
        else
            in_service_bits <= (in_service_bits & ~service_clear)
                | service_set;
    end
endmodule : ipsl_top

// ### pkg/ipsl_pkg.sv
// constants for the interrupt priority and status logic
// assumes a single 25 MHz clock and an AHB-Lite register port
// Summary of operation
// - requests with priority code above threshold blocked
// - threshold codes levels directly, resets to seven
// - read-only in-service bit per channel 0..14
// - end-of-interrupt clears in-service bit
// - level channels mirror source, inverted if active low
// - edge request sets on edge, clears at service
// - internal requests clear when service starts
// - channel 0 request is OR of timer bits
// - channels 9/10 follow pin or DMA pair
// - status holds four DMA and three timer bits
// - software writes only clear status bits
// - vector fetch clears only its own device bit
// - status clear by fetch sets channel in-service
// - halt flag: NMI sets, return clears, writable
// - shared status maps I/O and external pins
// - shared channel accepts listed pins as sources
// - pulse-width events replace pins 7 and 8
// - shared sources are level-triggered, held until served
// - shared mask bit zero enables, resets to one
// - polarity bit zero active low, one high
package ipsl_pkg;
    localparam int NUM_CH = 15;
    localparam int NUM_EXT = 9;
    localparam int NUM_GPIO = 8;
    // register indexes; byte address is four times the index
    localparam logic [9:0] IDX_PRIORITY_THRESHOLD = 10'h328;
    localparam logic [9:0] IDX_IN_SERVICE = 10'h32a;
    localparam logic [9:0] IDX_CHANNEL_REQUEST = 10'h32c;
    localparam logic [9:0] IDX_TIMER_DMA_STATUS = 10'h32e;
    localparam logic [9:0] IDX_DMA_HALT = 10'h330;
    localparam logic [9:0] IDX_SHARED_STATUS = 10'h332;
    localparam logic [9:0] IDX_SHARED_MASK = 10'h334;
    localparam logic [9:0] IDX_EXT_POLARITY = 10'h336;
    localparam logic [9:0] IDX_GPIO_POLARITY = 10'h338;
    localparam logic [9:0] IDX_TRIGGER_MODE = 10'h33a;
    localparam logic [9:0] IDX_SOURCE_CONFIG = 10'h33c;
    // field layout
    localparam int THR_W = 3;
    localparam int TIM_LSB = 0;
    localparam int TIM_W = 3;
    localparam int DMA_LSB = 3;
    localparam int DMA_W = 4;
    localparam int HALT_BIT = 15;
    localparam int SH_GPIO_LSB = 8;
    localparam int SH_EXT_LSB = 1;
    localparam int SH_EXT_W = 7;
    localparam int CFG_CH9_DMA = 0;
    localparam int CFG_CH10_DMA = 1;
    localparam int CFG_PWD = 2;
    localparam int CFG_W = 3;
    // channel numbers
    localparam int CH_TIMER = 0;
    localparam int CH_DMA_LO = 9;
    localparam int CH_DMA_HI = 10;
    localparam int CH_PWD_A = 12;
    localparam int CH_PWD_B = 13;
    localparam int CH_SHARED = 14;
    // reset values
    localparam logic [2:0] THRESHOLD_RESET = 3'h7;
    localparam logic [15:0] SHARED_MASK_RESET = 16'hffff;
    localparam logic [8:0] EXT_POL_RESET = 9'h1ff;
    localparam logic [7:0] GPIO_POL_RESET = 8'hff;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;
    localparam logic [2:0] HSIZE_WORD = 3'b010;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : ipsl_pkg

// ### verilog/ipsl_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes the pins are quasi-static relative to mclk
`timescale 1ns/10ps
module ipsl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : ipsl_sync

// ### testbench/ipsl_checker_assertions.sv
// checker bound to ipsl_top: service, halt, request and reset relations
// assumes one mclk domain and a synchronous active-high rst
`timescale 1ns/10ps
module ipsl_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [14:0] channel_mask,
    input wire logic [2:0] timer_event,
    input wire logic [3:0] internal_request,
    input wire logic vector_fetch,
    input wire logic [3:0] vector_channel,
    input wire logic eoi_specific,
    input wire logic [3:0] eoi_channel,
    input wire logic eoi_nonspecific,
    input wire logic nmi_event,
    input wire logic interrupt_return,
    input wire logic [14:0] channel_request_bits,
    input wire logic [14:0] in_service_bits,
    input wire logic [14:0] request_allowed,
    input wire logic dma_halt_flag,
    input wire logic shared_channel_request
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_fetch_sets:
    assert property (vector_fetch && vector_channel < 4'hf
        |=> in_service_bits[$past(vector_channel)])
        else $error("vector fetch left in-service bit clear");
    a_eoi_clear:
    assert property (eoi_specific && !vector_fetch && eoi_channel < 4'hf
        |=> !in_service_bits[$past(eoi_channel)])
        else $error("specific eoi left in-service bit set");
    a_nonspec_one:
    assert property (eoi_nonspecific && !eoi_specific && !vector_fetch &&
        in_service_bits != 15'h0 |=> $countones(in_service_bits) ==
        $countones($past(in_service_bits)) - 1)
        else $error("non-specific eoi did not clear one bit");
    a_halt_set:
    assert property (nmi_event |=> dma_halt_flag)
        else $error("nmi did not set halt");
    a_halt_clear:
    assert property (interrupt_return && !nmi_event |=> !dma_halt_flag)
        else $error("return did not clear halt");
    a_timer_req:
    assert property (|timer_event |=> channel_request_bits[0])
        else $error("timer event did not raise channel 0");
    a_int_clear:
    assert property (vector_fetch && vector_channel == 4'h4 &&
        !internal_request[0] |=> !channel_request_bits[4])
        else $error("internal request kept after service");
    a_allowed_gate:
    assert property ((request_allowed &
        ~(channel_request_bits & ~channel_mask)) == 15'h0)
        else $error("allowed without unmasked request");
    a_reset_clear:
    assert property ($fell(rst) |-> in_service_bits == 15'h0 &&
        !dma_halt_flag && !shared_channel_request)
        else $error("state not cleared by reset");

    c_fetch: cover property (vector_fetch);
    c_nmi: cover property (nmi_event ##1 dma_halt_flag);
    c_shared: cover property (shared_channel_request);
endmodule : ipsl_checker

bind ipsl_top ipsl_checker u_ipsl_checker (.mclk(mclk), .rst(rst),
    .channel_mask(channel_mask), .timer_event(timer_event),
    .internal_request(internal_request), .vector_fetch(vector_fetch),
    .vector_channel(vector_channel), .eoi_specific(eoi_specific),
    .eoi_channel(eoi_channel), .eoi_nonspecific(eoi_nonspecific),
    .nmi_event(nmi_event), .interrupt_return(interrupt_return),
    .channel_request_bits(channel_request_bits),
    .in_service_bits(in_service_bits), .request_allowed(request_allowed),
    .dma_halt_flag(dma_halt_flag),
    .shared_channel_request(shared_channel_request));

// ### testbench/ipsl_core_model.sv
// core-side model: AHB-Lite master and interrupt acknowledge strobes
// assumes one slave whose hreadyout comes back as hready
`timescale 1ns/10ps
module ipsl_core_model (
    input wire logic mclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic vector_fetch,
    output logic [3:0] vector_channel,
    output logic [1:0] vector_device,
    output logic eoi_specific,
    output logic [3:0] eoi_channel,
    output logic eoi_nonspecific,
    output logic nmi_event,
    output logic interrupt_return
);
    import ipsl_pkg::*;
    initial
    begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
        {vector_fetch, vector_channel, vector_device, eoi_specific} = '0;
        {eoi_channel, eoi_nonspecific, nmi_event, interrupt_return} = '0;
    end

    // called just after a rising edge; returns at the edge ending data
    task automatic xfer(input logic w, input logic [9:0] idx,
        input logic [31:0] wd, output logic [31:0] rdata);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rdata = hrdata;
        // released data must not look like a still-valid value
        hwdata <= ~wd;
    endtask : xfer

    // kind: 0 fetch, 1 specific eoi, 2 non-specific eoi, 3 nmi, 4 return
    task automatic strobe(input int kind, input logic [3:0] ch,
        input logic [1:0] dev);
        vector_channel <= ch;
        vector_device <= dev;
        eoi_channel <= ch;
        vector_fetch <= (kind == 0);
        eoi_specific <= (kind == 1);
        eoi_nonspecific <= (kind == 2);
        nmi_event <= (kind == 3);
        interrupt_return <= (kind == 4);
        @(posedge mclk);
        {vector_fetch, eoi_specific, eoi_nonspecific} <= '0;
        {nmi_event, interrupt_return} <= '0;
        vector_channel <= ~ch;
        @(posedge mclk);
    endtask : strobe
endmodule : ipsl_core_model

// ### testbench/interrupt_priority_status_logic_bench.sv
// self-checking bench for the interrupt priority and status logic
// assumes the core model is the only bus master and strobe source
`timescale 1ns/10ps
module interrupt_priority_status_logic_bench;
    import ipsl_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] external_interrupt_pins = '0;
    logic [7:0] general_io_pin = '0;
    logic [2:0] timer_event = '0;
    logic [3:0] dma_event = '0;
    logic [3:0] internal_request = '0;
    logic pwd_rise_event = 1'b0;
    logic pwd_fall_event = 1'b0;
    logic [14:0] channel_mask = '0;
    logic [44:0] channel_priority_field = '0;
    logic hsel, hwrite, hready, hreadyout, hresp, vector_fetch;
    logic eoi_specific, eoi_nonspecific, nmi_event, interrupt_return;
    logic dma_halt_flag, shared_channel_request;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, vector_device;
    logic [2:0] hsize;
    logic [3:0] vector_channel, eoi_channel;
    logic [14:0] channel_request_bits, in_service_bits, request_allowed;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    integer seed = 32'hf1c2_b61b;

    always #20 mclk = ~mclk;
    assign hready = hreadyout;
    ipsl_top u_ipsl_top (.*);
    ipsl_core_model u_ipsl_core_model (.*);

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        u_ipsl_core_model.xfer(1'b0, idx, 32'h0, v);
        cmp(v, exp);
        cmp({31'h0, hresp}, 32'h0);
    endtask : rd

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] v;
        u_ipsl_core_model.xfer(1'b1, idx, d, v);
    endtask : wr

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic done(input string s);
        $display("test %s done, errors so far %0d", s, errors);
    endtask : done

    function automatic logic [31:0] allow_exp(input logic [2:0] t);
        allow_exp = 32'h0;
        for (int c = 4; c < 8; c++)
            allow_exp[c-4] = !channel_mask[c] &&
                channel_priority_field[3*c +: 3] <= t;
    endfunction : allow_exp

    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            $display("FAIL %0t run did not finish", $time);
            report_and_stop();
        end
    end

    initial
    begin
        tick(10);
        rst <= 1'b0;
        tick(1);
        rd(IDX_PRIORITY_THRESHOLD, 32'h0000_0007);
        rd(IDX_IN_SERVICE, 32'h0);
        rd(IDX_CHANNEL_REQUEST, 32'h0);
        rd(IDX_TIMER_DMA_STATUS, 32'h0);
        rd(IDX_DMA_HALT, 32'h0);
        rd(IDX_SHARED_STATUS, 32'h0);
        rd(IDX_SHARED_MASK, 32'h0000_ffff);
        rd(10'h3fe, 32'h0);
        done("reset");
        timer_event <= 3'h5;
        dma_event <= 4'h7;
        tick(1);
        timer_event <= 3'h0;
        dma_event <= 4'h0;
        tick(1);
        rd(IDX_TIMER_DMA_STATUS, 32'h0000_003d);
        cmp({31'h0, channel_request_bits[0]}, 32'h1);
        wr(IDX_TIMER_DMA_STATUS, 32'h0000_007f);
        rd(IDX_TIMER_DMA_STATUS, 32'h0000_003d);
        wr(IDX_TIMER_DMA_STATUS, 32'h0000_0039);
        rd(IDX_TIMER_DMA_STATUS, 32'h0000_0039);
        u_ipsl_core_model.strobe(0, 4'h0, 2'h0);
        rd(IDX_TIMER_DMA_STATUS, 32'h0000_0038);
        rd(IDX_IN_SERVICE, 32'h0000_0001);
        cmp({31'h0, channel_request_bits[0]}, 32'h0);
        wr(IDX_SOURCE_CONFIG, 32'h0000_0003);
        tick(1);
        cmp({31'h0, channel_request_bits[9]}, 32'h1);
        cmp({31'h0, channel_request_bits[10]}, 32'h1);
        u_ipsl_core_model.strobe(0, 4'h9, 2'h0);
        rd(IDX_TIMER_DMA_STATUS, 32'h0000_0030);
        cmp({31'h0, channel_request_bits[9]}, 32'h1);
        u_ipsl_core_model.strobe(1, 4'h9, 2'h0);
        rd(IDX_IN_SERVICE, 32'h0000_0001);
        u_ipsl_core_model.strobe(2, 4'h0, 2'h0);
        rd(IDX_IN_SERVICE, 32'h0);
        done("status");
        internal_request <= 4'hf;
        tick(1);
        internal_request <= 4'h0;
        for (int t = 0; t < 8; t++)
        begin
            channel_mask <= 15'($random(seed));
            channel_priority_field <= {13'h0, $random(seed)};
            wr(IDX_PRIORITY_THRESHOLD, t);
            tick(1);
            rd(IDX_PRIORITY_THRESHOLD, t);
            cmp({28'h0, request_allowed[7:4]}, allow_exp(3'(t)));
        end
        u_ipsl_core_model.strobe(0, 4'h4, 2'h0);
        cmp({28'h0, channel_request_bits[7:4]}, 32'h0000_000e);
        done("threshold");
        u_ipsl_core_model.strobe(3, 4'h0, 2'h0);
        rd(IDX_DMA_HALT, 32'h0000_8000);
        u_ipsl_core_model.strobe(4, 4'h0, 2'h0);
        rd(IDX_DMA_HALT, 32'h0);
        wr(IDX_DMA_HALT, 32'h0000_8000);
        rd(IDX_DMA_HALT, 32'h0000_8000);
        done("halt");
        wr(IDX_SHARED_MASK, 32'h0000_7ffd);
        // sources stay active until the checks below see them
        external_interrupt_pins <= 9'h002;
        general_io_pin <= 8'h80; // pin set up as an input
        tick(4);
        rd(IDX_SHARED_STATUS, 32'h0000_8002);
        cmp({31'h0, shared_channel_request}, 32'h1);
        cmp({31'h0, channel_request_bits[2]}, 32'h1);
        wr(IDX_GPIO_POLARITY, 32'h0000_7fff);
        wr(IDX_EXT_POLARITY, 32'h0000_fffd);
        tick(4);
        rd(IDX_SHARED_STATUS, 32'h0);
        cmp({31'h0, shared_channel_request}, 32'h0);
        cmp({31'h0, channel_request_bits[2]}, 32'h0);
        done("shared");
        wr(IDX_TRIGGER_MODE, 32'h0000_0100);
        external_interrupt_pins <= 9'h00a;
        tick(4);
        cmp({31'h0, channel_request_bits[8]}, 32'h1);
        u_ipsl_core_model.strobe(0, 4'h8, 2'h0);
        cmp({31'h0, channel_request_bits[8]}, 32'h0);
        wr(IDX_SOURCE_CONFIG, 32'h0000_0004);
        pwd_rise_event <= 1'b1;
        pwd_fall_event <= 1'b1;
        tick(1);
        pwd_rise_event <= 1'b0;
        pwd_fall_event <= 1'b0;
        tick(1);
        cmp({30'h0, channel_request_bits[13:12]}, 32'h3);
        done("edge and pwd");
        report_and_stop();
    end
endmodule : interrupt_priority_status_logic_bench
